// ===== hdl/pmpi_pkg.sv
// Package with the register map, reset values and carrier types of the port M/P pin block.
package pmpi_pkg;

	// ==========================================================
	// Register indices (printed offsets are not all word aligned).
	localparam logic [5:0] IDX_M_DATA = 6'h10;
	localparam logic [5:0] IDX_M_PIN_INPUT = 6'h11;
	localparam logic [5:0] IDX_M_DIRECTION = 6'h12;
	localparam logic [5:0] IDX_M_DRIVE_SELECT = 6'h13;
	localparam logic [5:0] IDX_M_PULL_ENABLE = 6'h14;
	localparam logic [5:0] IDX_M_PULL_POLARITY = 6'h15;
	localparam logic [5:0] IDX_M_OPEN_DRAIN = 6'h16;
	localparam logic [5:0] IDX_MODULE_ROUTING = 6'h17;
	localparam logic [5:0] IDX_P_DATA = 6'h18;
	localparam logic [5:0] IDX_P_PIN_INPUT = 6'h19;
	localparam logic [5:0] IDX_P_DIRECTION = 6'h1a;
	localparam logic [5:0] IDX_P_DRIVE_SELECT = 6'h1b;
	localparam logic [5:0] IDX_P_PULL_ENABLE = 6'h1c;
	localparam logic [5:0] IDX_P_EDGE_POLARITY = 6'h1d;
	localparam logic [5:0] IDX_P_IRQ_ENABLE = 6'h1e;
	localparam logic [5:0] IDX_P_IRQ_FLAGS = 6'h1f;

	// ==========================================================
	// Reset values and field positions.
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
	localparam int ROUTE_CAN_CTRL_SECOND_LSB = 0;
	localparam int ROUTE_CAN5_LSB = 2;
	localparam int ROUTE_SPI_UNIT_SECOND_BIT = 4;
	localparam logic [1:0] CAN_CTRL_SECOND_ON_M10 = 2'h0;
	localparam logic [1:0] CAN_CTRL_SECOND_ON_M32 = 2'h1;
	localparam logic [1:0] CAN_CTRL_SECOND_ON_M54 = 2'h2;
	localparam logic [1:0] CAN5_ON_M54 = 2'h1;
	localparam logic [1:0] CAN5_ON_M76 = 2'h2;
	localparam int SYNC_STAGES = 2;

	// ==========================================================
	// Carrier types.
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] reduced;
		logic [7:0] pull_en;
		logic [7:0] pull_down;
	} pmpi_pad_type;

	typedef struct packed {
		logic can_first_en;
		logic can_first_tx;
		logic can_second_en;
		logic can_second_tx;
		logic can_fifth_en;
		logic can_fifth_tx;
		logic spi_first_en;
		logic spi_first_bidir;
		logic spi_first_sck;
		logic spi_first_mosi;
		logic spi_first_sck_oe;
		logic spi_first_mosi_oe;
		logic spi_first_ss;
		logic spi_first_miso;
		logic spi_first_ss_oe;
		logic spi_first_miso_oe;
	} pmpi_mperiph_type;

	typedef struct packed {
		logic [7:0] pwm_en;
		logic pwm7_shutdown;
		logic [7:0] pwm_out;
		logic [7:0] spi_en;
		logic [7:0] spi_out;
		logic [7:0] spi_oe;
	} pmpi_pperiph_type;

endpackage

// ===== hdl/pmpi_top.sv
// Port M and port P pin integration: registers, pin muxing and port P edge flags.
// Functional notes
// - Data read gives output latch for output bits, synced pin for input bits.
// - Pin input register is read only and always shows pin levels.
// - After direction change, readback may lag up to two bus cycles; pad flop plus two sync stages give three here.
// - Port M 7:6 owned by fifth CAN when enabled and routed there.
// - Port M 5:4 priority: first CAN, fifth CAN, first SPI, GPIO.
// - Port M 3:2 priority: second CAN, first CAN, non-bidir first SPI, GPIO.
// - Port M 1:0 owned by first CAN when enabled and routed there.
// - Enabled CAN forces transmit out, receive in; stored direction unchanged.
// - Reduced drive bit selects third strength; ignored on inputs.
// - Port M pull acts on inputs or open-drain outputs only; reset off.
// - Port M pull-down on any pin but CAN receive; pull-up allowed on any pin.
// - Port M open drain never drives high, CAN pins too; inputs unaffected.
// - Routing bits 1:0 place first CAN on M0/1, M2/3, M4/5 or J.
// - Routing bits 3:2 place fifth CAN on J, M4/5, M6/7; 11 reserved.
// - Routing bit 4 moves first SPI from port S to M2,4,5,3.
// - Routing bits 5 and 6 move second and third SPI off port P.
// - On port P PWM beats SPI beats GPIO; channel 7 may be input.
// - PWM forces output, channel 7 shutdown input; SPI sets direction itself.
// - Port P pull acts only on inputs; all off after reset.
// - Port P polarity 1 rising edge and pull-down, 0 falling and pull-up.
// - Interrupt requested only when flag and its enable are both 1.
// - Selected edge sets flag; writing 1 clears, writing 0 no effect.
`timescale 1ns/1ps
module pmpi_top (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [5:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [7:0] i_pm_pin,
	input wire logic [7:0] i_pp_pin,
	input wire pmpi_pkg::pmpi_mperiph_type i_mperiph,
	input wire pmpi_pkg::pmpi_pperiph_type i_pperiph,
	output pmpi_pkg::pmpi_pad_type o_pm_pad,
	output pmpi_pkg::pmpi_pad_type o_pp_pad,
	output logic [7:0] o_pm_sync,
	output logic [7:0] o_pp_sync,
	output logic [6:0] o_route,
	output logic o_pp_irq
);

	// ==========================================================
	// Register storage.
	logic [7:0] m_data_q, m_dir_q, m_rdr_q, m_pe_q, m_ps_q, m_od_q, route_q;
	logic [7:0] p_data_q, p_dir_q, p_rdr_q, p_pe_q, p_ps_q, p_ie_q, p_if_q;
	logic [7:0] pm_s1_q, pm_s2_q, pp_s1_q, pp_s2_q, pp_prev_q;
	logic [31:0] rdata_q;
	logic ack_q, ack_d;
	logic [7:0] p_edge, p_clr, p_ie_nx;
	logic wr_hit, rd_hit;

	// A one-cycle wait state per access keeps readdata registered.
	assign wr_hit = i_avs_write && !ack_q && i_avs_byteenable[0];
	assign rd_hit = i_avs_read && !ack_q;
	// Every request is answered once, whether or not it hits a register.
	assign ack_d = (i_avs_read || i_avs_write) && !ack_q;

	// ==========================================================
	// Pin synchronisers: two flops before any logic looks at a pin.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pm_s1_q <= pmpi_pkg::RST_ZERO;
			pm_s2_q <= pmpi_pkg::RST_ZERO;
			pp_s1_q <= pmpi_pkg::RST_ZERO;
			pp_s2_q <= pmpi_pkg::RST_ZERO;
			pp_prev_q <= pmpi_pkg::RST_ZERO;
		end else begin
			pm_s1_q <= i_pm_pin;
			pm_s2_q <= pm_s1_q;
			pp_s1_q <= i_pp_pin;
			pp_s2_q <= pp_s1_q;
			pp_prev_q <= pp_s2_q;
		end
	end

	// ==========================================================
	// Software-written registers.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			m_data_q <= pmpi_pkg::RST_ZERO;
			m_dir_q <= pmpi_pkg::RST_ZERO;
			m_rdr_q <= pmpi_pkg::RST_ZERO;
			m_pe_q <= pmpi_pkg::RST_ZERO;
			m_ps_q <= pmpi_pkg::RST_ZERO;
			m_od_q <= pmpi_pkg::RST_ZERO;
			route_q <= pmpi_pkg::RST_ZERO;
			p_data_q <= pmpi_pkg::RST_ZERO;
			p_dir_q <= pmpi_pkg::RST_ZERO;
			p_rdr_q <= pmpi_pkg::RST_ZERO;
			p_pe_q <= pmpi_pkg::RST_ZERO;
			p_ps_q <= pmpi_pkg::RST_ZERO;
			p_ie_q <= pmpi_pkg::RST_ZERO;
		end else if (wr_hit) begin
			// Pin input and flag registers are not stored here, so writes to
			// the pin input index simply fall through.
			case (i_avs_address)
				pmpi_pkg::IDX_M_DATA: m_data_q <= i_avs_writedata[7:0];
				pmpi_pkg::IDX_M_DIRECTION: m_dir_q <= i_avs_writedata[7:0];
				pmpi_pkg::IDX_M_DRIVE_SELECT: m_rdr_q <= i_avs_writedata[7:0];
				pmpi_pkg::IDX_M_PULL_ENABLE: m_pe_q <= i_avs_writedata[7:0];
				pmpi_pkg::IDX_M_PULL_POLARITY: m_ps_q <= i_avs_writedata[7:0];
				pmpi_pkg::IDX_M_OPEN_DRAIN: m_od_q <= i_avs_writedata[7:0];
				pmpi_pkg::IDX_MODULE_ROUTING: route_q <= {1'b0, i_avs_writedata[6:0]};
				pmpi_pkg::IDX_P_DATA: p_data_q <= i_avs_writedata[7:0];
				pmpi_pkg::IDX_P_DIRECTION: p_dir_q <= i_avs_writedata[7:0];
				pmpi_pkg::IDX_P_DRIVE_SELECT: p_rdr_q <= i_avs_writedata[7:0];
				pmpi_pkg::IDX_P_PULL_ENABLE: p_pe_q <= i_avs_writedata[7:0];
				pmpi_pkg::IDX_P_EDGE_POLARITY: p_ps_q <= i_avs_writedata[7:0];
				pmpi_pkg::IDX_P_IRQ_ENABLE: p_ie_q <= i_avs_writedata[7:0];
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Port P edge flags. A new edge beats a clearing write in the same cycle.
	always_comb begin
		p_clr = (wr_hit && i_avs_address == pmpi_pkg::IDX_P_IRQ_FLAGS) ?
			i_avs_writedata[7:0] : pmpi_pkg::RST_ZERO;
		p_ie_nx = (wr_hit && i_avs_address == pmpi_pkg::IDX_P_IRQ_ENABLE) ?
			i_avs_writedata[7:0] : p_ie_q;
		p_edge = (p_ps_q & pp_s2_q & ~pp_prev_q) |
			(~p_ps_q & ~pp_s2_q & pp_prev_q);
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			p_if_q <= pmpi_pkg::RST_ZERO;
		end else begin
			p_if_q <= (p_if_q & ~p_clr) | p_edge;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_pp_irq <= 1'b0;
		end else begin
			// Next flag and enable values, so a masking write drops the line at once.
			o_pp_irq <= |(((p_if_q & ~p_clr) | p_edge) & p_ie_nx);
		end
	end

	// ==========================================================
	// Port M ownership: per pin, output value, drive enable, CAN receive mark.
	logic [1:0] c1_rt, c5_rt;
	logic c1_m10, c1_m32, c1_m54, c5_m54, c5_m76, s1_m;
	logic [7:0] m_own, m_oval, m_oe_per, m_canrx, m_oe, m_val;

	assign c1_rt = route_q[pmpi_pkg::ROUTE_CAN_CTRL_SECOND_LSB +: 2];
	assign c5_rt = route_q[pmpi_pkg::ROUTE_CAN5_LSB +: 2];

	always_comb begin
		c1_m10 = i_mperiph.can_first_en && c1_rt == pmpi_pkg::CAN_CTRL_SECOND_ON_M10;
		c1_m32 = i_mperiph.can_first_en && c1_rt == pmpi_pkg::CAN_CTRL_SECOND_ON_M32;
		c1_m54 = i_mperiph.can_first_en && c1_rt == pmpi_pkg::CAN_CTRL_SECOND_ON_M54;
		c5_m54 = i_mperiph.can_fifth_en && c5_rt == pmpi_pkg::CAN5_ON_M54;
		c5_m76 = i_mperiph.can_fifth_en && c5_rt == pmpi_pkg::CAN5_ON_M76;
		s1_m = i_mperiph.spi_first_en && route_q[pmpi_pkg::ROUTE_SPI_UNIT_SECOND_BIT];
		m_own = pmpi_pkg::RST_ZERO;
		m_oval = pmpi_pkg::RST_ZERO;
		m_oe_per = pmpi_pkg::RST_ZERO;
		m_canrx = pmpi_pkg::RST_ZERO;
		// Bits 7:6, fifth CAN only.
		if (c5_m76) begin
			m_own[7:6] = 2'h3;
			m_oval[7] = i_mperiph.can_fifth_tx;
			m_oe_per[7:6] = 2'h2;
			m_canrx[6] = 1'b1;
		end
		// Bits 5:4.
		if (c1_m54) begin
			m_own[5:4] = 2'h3;
			m_oval[5] = i_mperiph.can_first_tx;
			m_oe_per[5:4] = 2'h2;
			m_canrx[4] = 1'b1;
		end else if (c5_m54) begin
			m_own[5:4] = 2'h3;
			m_oval[5] = i_mperiph.can_fifth_tx;
			m_oe_per[5:4] = 2'h2;
			m_canrx[4] = 1'b1;
		end else if (s1_m) begin
			m_own[5:4] = 2'h3;
			m_oval[5:4] = {i_mperiph.spi_first_sck, i_mperiph.spi_first_mosi};
			m_oe_per[5:4] = {i_mperiph.spi_first_sck_oe, i_mperiph.spi_first_mosi_oe};
		end
		// Bits 3:2. Second CAN has no routing field and sits here when enabled.
		if (i_mperiph.can_second_en) begin
			m_own[3:2] = 2'h3;
			m_oval[3] = i_mperiph.can_second_tx;
			m_oe_per[3:2] = 2'h2;
			m_canrx[2] = 1'b1;
		end else if (c1_m32) begin
			m_own[3:2] = 2'h3;
			m_oval[3] = i_mperiph.can_first_tx;
			m_oe_per[3:2] = 2'h2;
			m_canrx[2] = 1'b1;
		end else if (s1_m && !i_mperiph.spi_first_bidir) begin
			m_own[3:2] = 2'h3;
			m_oval[3:2] = {i_mperiph.spi_first_ss, i_mperiph.spi_first_miso};
			m_oe_per[3:2] = {i_mperiph.spi_first_ss_oe, i_mperiph.spi_first_miso_oe};
		end
		// Bits 1:0, first CAN only.
		if (c1_m10) begin
			m_own[1:0] = 2'h3;
			m_oval[1] = i_mperiph.can_first_tx;
			m_oe_per[1:0] = 2'h2;
			m_canrx[0] = 1'b1;
		end
		// Stored direction untouched; peripherals only override the pad.
		m_oe = (m_own & m_oe_per) | (~m_own & m_dir_q);
		m_val = (m_own & m_oval) | (~m_own & m_data_q);
	end

	// ==========================================================
	// Port P ownership: PWM over SPI over GPIO.
	logic [7:0] p_pwm, p_spi, p_oe, p_val, p_pwm_oe;

	always_comb begin
		p_pwm = i_pperiph.pwm_en;
		p_pwm_oe = 8'hff;
		p_pwm_oe[7] = !i_pperiph.pwm7_shutdown;
		// Second/third SPI leave port P when rerouted to port H.
		p_spi = ~p_pwm & i_pperiph.spi_en &
			{{4{!route_q[6]}}, {4{!route_q[5]}}};
		p_oe = (p_pwm & p_pwm_oe) | (p_spi & i_pperiph.spi_oe) |
			(~p_pwm & ~p_spi & p_dir_q);
		p_val = (p_pwm & i_pperiph.pwm_out) | (p_spi & i_pperiph.spi_out) |
			(~p_pwm & ~p_spi & p_data_q);
	end

	// ==========================================================
	// Pad control flops: every pad output is registered.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_pm_pad <= '0;
			o_pp_pad <= '0;
			o_route <= 7'h00;
		end else begin
			// Open drain drives only lows, so a high turns the driver off.
			o_pm_pad.oe <= m_oe & ~(m_od_q & m_val);
			o_pm_pad.out <= m_val & ~m_od_q;
			o_pm_pad.reduced <= m_rdr_q & m_oe;
			o_pm_pad.pull_en <= m_pe_q & (~m_oe | m_od_q) &
				~(m_ps_q & m_canrx);
			o_pm_pad.pull_down <= m_ps_q & ~m_canrx;
			o_pp_pad.oe <= p_oe;
			o_pp_pad.out <= p_val;
			o_pp_pad.reduced <= p_rdr_q & p_oe;
			o_pp_pad.pull_en <= p_pe_q & ~p_oe;
			o_pp_pad.pull_down <= p_ps_q;
			o_route <= route_q[6:0];
		end
	end

	// Synced pin levels feed the peripherals' receive inputs.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_pm_sync <= pmpi_pkg::RST_ZERO;
			o_pp_sync <= pmpi_pkg::RST_ZERO;
		end else begin
			o_pm_sync <= pm_s2_q;
			o_pp_sync <= pp_s2_q;
		end
	end

	// ==========================================================
	// Avalon read path and wait state.
	logic [7:0] rd_byte;
	logic rd_map;

	always_comb begin
		rd_map = 1'b1;
		case (i_avs_address)
			pmpi_pkg::IDX_M_DATA: rd_byte = (m_dir_q & m_data_q) | (~m_dir_q & pm_s2_q);
			pmpi_pkg::IDX_M_PIN_INPUT: rd_byte = pm_s2_q;
			pmpi_pkg::IDX_M_DIRECTION: rd_byte = m_dir_q;
			pmpi_pkg::IDX_M_DRIVE_SELECT: rd_byte = m_rdr_q;
			pmpi_pkg::IDX_M_PULL_ENABLE: rd_byte = m_pe_q;
			pmpi_pkg::IDX_M_PULL_POLARITY: rd_byte = m_ps_q;
			pmpi_pkg::IDX_M_OPEN_DRAIN: rd_byte = m_od_q;
			pmpi_pkg::IDX_MODULE_ROUTING: rd_byte = route_q;
			pmpi_pkg::IDX_P_DATA: rd_byte = (p_dir_q & p_data_q) | (~p_dir_q & pp_s2_q);
			pmpi_pkg::IDX_P_PIN_INPUT: rd_byte = pp_s2_q;
			pmpi_pkg::IDX_P_DIRECTION: rd_byte = p_dir_q;
			pmpi_pkg::IDX_P_DRIVE_SELECT: rd_byte = p_rdr_q;
			pmpi_pkg::IDX_P_PULL_ENABLE: rd_byte = p_pe_q;
			pmpi_pkg::IDX_P_EDGE_POLARITY: rd_byte = p_ps_q;
			pmpi_pkg::IDX_P_IRQ_ENABLE: rd_byte = p_ie_q;
			pmpi_pkg::IDX_P_IRQ_FLAGS: rd_byte = p_if_q;
			default: begin
				rd_byte = pmpi_pkg::RST_ZERO;
				rd_map = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ack_q <= 1'b0;
			o_avs_waitrequest <= 1'b1;
			rdata_q <= pmpi_pkg::RD_UNMAPPED;
		end else begin
			// Waitrequest has its own flop so the bus never sees a gate output.
			ack_q <= ack_d;
			o_avs_waitrequest <= !ack_d;
			if (rd_hit) begin
				rdata_q <= rd_map ? {24'h00_0000, rd_byte} : pmpi_pkg::RD_UNMAPPED;
			end
		end
	end

	assign o_avs_readdata = rdata_q;

	// ==========================================================
	// Checks.
	sequence flag_clear_write(int b);
		wr_hit && i_avs_address == pmpi_pkg::IDX_P_IRQ_FLAGS && i_avs_writedata[b];
	endsequence

	sequence pin_input_read;
		rd_hit && i_avs_address == pmpi_pkg::IDX_M_PIN_INPUT;
	endsequence

	flag_set_edge_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		p_edge[0] |=> p_if_q[0]) else $error("Flag not set by edge.");
	flag_w1c_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		flag_clear_write(0) ##0 !p_edge[0] |=> !p_if_q[0]) else $error("Flag not cleared.");
	// A clearing write that meets a new edge must leave that flag set.
	edge_wins_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		flag_clear_write(3) ##0 p_edge[3] |=> p_if_q[3]) else $error("Clear beat edge.");
	flag_keep_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		p_if_q[1] && !p_clr[1] |=> p_if_q[1]) else $error("Flag lost without clear.");
	irq_mask_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(p_if_q & p_ie_q) == 8'h00 |-> !o_pp_irq)
		else $error("Masked flag raised request.");
	irq_follow_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(p_if_q & p_ie_q) != 8'h00 |-> o_pp_irq)
		else $error("Enabled flag gave no request.");
	pin_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		pin_input_read |=> o_avs_readdata[7:0] == $past(pm_s2_q))
		else $error("Pin input read wrong.");
	edge_rise_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		p_ps_q[2] && $rose(pp_s2_q[2]) |-> p_edge[2]) else $error("Rising edge missed.");
	can_tx_out_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		c1_m10 && !m_od_q[1] |=> o_pm_pad.oe[1] && !o_pm_pad.oe[0])
		else $error("CAN pin direction wrong.");
	od_no_high_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(o_pm_pad.oe & o_pm_pad.out & $past(m_od_q)) == 8'h00)
		else $error("Open drain drove high.");
	// Pad flops lag the registers by one edge, hence the past values.
	pull_push_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(o_pm_pad.pull_en & o_pm_pad.oe & ~$past(m_od_q)) == 8'h00)
		else $error("Pull on push-pull output.");
	canrx_no_down_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(o_pm_pad.pull_en & o_pm_pad.pull_down & $past(m_canrx)) == 8'h00)
		else $error("Pull-down on CAN receive.");
	pull_p_out_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(o_pp_pad.pull_en & o_pp_pad.oe) == 8'h00) else $error("Pull on port P output.");
	reduced_in_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(o_pp_pad.reduced & ~o_pp_pad.oe) == 8'h00) else $error("Reduced drive on input.");
	sync_delay_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		##2 pm_s2_q == $past(i_pm_pin, 2)) else $error("Sync depth wrong.");
	pwm_out_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_pperiph.pwm_en[0] |=> o_pp_pad.oe[0]) else $error("PWM pin not output.");

endmodule

// ===== sim/pmpi_pins.sv
// Pin model standing at the far side of one eight-bit port of the pin block.
`timescale 1ns/1ps
module pmpi_pins (
	input wire logic i_clk,
	input wire pmpi_pkg::pmpi_pad_type i_pad,
	input wire logic i_ext_en,
	input wire logic [7:0] i_ext,
	output logic [7:0] o_pin
);
	// ==========================================================
	// Pin resolution
	logic [7:0] last_q;

	// A floating pin with no pull shows the inverse of its last level, so stale values never match.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (i_pad.oe[i]) begin
				o_pin[i] = i_pad.out[i];
			end else if (i_ext_en) begin
				o_pin[i] = i_ext[i];
			end else if (i_pad.pull_en[i]) begin
				o_pin[i] = ~i_pad.pull_down[i];
			end else begin
				o_pin[i] = ~last_q[i];
			end
		end
	end

	// Remember each level for the floating case.
	always_ff @(posedge i_clk) begin
		last_q <= o_pin;
	end
endmodule

// ===== sim/tb.sv
// Self-checking bench for the port M/P pin block with its two pin models.
`timescale 1ns/1ps
module tb;
	// ==========================================================
	// Signals
	logic i_clk;
	logic i_sys_rst;
	logic rd, wr, waitreq, irq, m_ext_en, p_ext_en;
	logic [3:0] be;
	logic [5:0] addr;
	logic [6:0] route;
	logic [7:0] pm_pin, pp_pin, m_ext, p_ext, q, pm_sync, pp_sync;
	logic [31:0] wdata, rdata;
	pmpi_pkg::pmpi_mperiph_type mper, mv;
	pmpi_pkg::pmpi_pperiph_type pper, pv;
	pmpi_pkg::pmpi_pad_type pm_pad, pp_pad;
	int mismatches, check_count;

	pmpi_top dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_pm_pin(pm_pin),
		.i_pp_pin(pp_pin), .i_mperiph(mper), .i_pperiph(pper), .o_pm_pad(pm_pad),
		.o_pp_pad(pp_pad), .o_pm_sync(pm_sync), .o_pp_sync(pp_sync), .o_route(route),
		.o_pp_irq(irq));
	pmpi_pins pins_m (.i_clk(i_clk), .i_pad(pm_pad), .i_ext_en(m_ext_en), .i_ext(m_ext),
		.o_pin(pm_pin));
	pmpi_pins pins_p (.i_clk(i_clk), .i_pad(pp_pad), .i_ext_en(p_ext_en), .i_ext(p_ext),
		.o_pin(pp_pin));

	// Free-running 25 MHz clock.
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// One bus access; the request is held until waitrequest is seen low.
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		int n;
		@(posedge i_clk);
		addr <= a;
		wr <= w;
		rd <= ~w;
		wdata <= {24'h00_0000, d};
		n = 0;
		// Waitrequest and readdata are read at the rising edge, before the flops move.
		do begin
			@(posedge i_clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		if (waitreq !== 1'b0) begin
			mismatches++;
			$display("unexpected at %0t: no bus answer", $time);
		end
		q = rdata[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic wreg(input logic [5:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		chk(q, exp);
	endtask

	// Pads are registered and pins pass two sync stages, so six cycles cover every path.
	task automatic settle;
		repeat (6) @(posedge i_clk);
		@(negedge i_clk);
	endtask

	task automatic set_m;
		@(posedge i_clk);
		mper <= mv;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		for (int i = 16; i < 32; i++) rchk(i[5:0], 8'h00);
		chk(pm_pad.pull_en, 8'h00);
		chk(pp_pad.pull_en, 8'h00);
		// A write without byte lane 0 must leave the register alone.
		@(posedge i_clk);
		be <= 4'h0;
		wreg(pmpi_pkg::IDX_M_DIRECTION, 8'hff);
		be <= 4'hf;
		rchk(pmpi_pkg::IDX_M_DIRECTION, 8'h00);
		wreg(6'h00, 8'hff);
		rchk(6'h00, 8'h00);
		wreg(pmpi_pkg::IDX_MODULE_ROUTING, 8'hff);
		rchk(pmpi_pkg::IDX_MODULE_ROUTING, 8'h7f);
		settle();
		chk({1'b0, route}, 8'h7f);
		wreg(pmpi_pkg::IDX_MODULE_ROUTING, 8'h00);
	endtask

	task automatic t_gpio;
		@(posedge i_clk);
		m_ext <= 8'h3c;
		wreg(pmpi_pkg::IDX_M_DIRECTION, 8'h0f);
		wreg(pmpi_pkg::IDX_M_DATA, 8'ha5);
		settle();
		chk(pm_sync, 8'h35);
		rchk(pmpi_pkg::IDX_M_DATA, 8'h35);
		wreg(pmpi_pkg::IDX_M_PIN_INPUT, 8'hff);
		rchk(pmpi_pkg::IDX_M_PIN_INPUT, 8'h35);
		wreg(pmpi_pkg::IDX_M_DIRECTION, 8'h00);
		settle();
		rchk(pmpi_pkg::IDX_M_DATA, 8'h3c);
		wreg(pmpi_pkg::IDX_M_DIRECTION, 8'h0f);
		wreg(pmpi_pkg::IDX_M_DRIVE_SELECT, 8'hff);
		wreg(pmpi_pkg::IDX_M_PULL_ENABLE, 8'hff);
		wreg(pmpi_pkg::IDX_M_PULL_POLARITY, 8'hf0);
		wreg(pmpi_pkg::IDX_M_OPEN_DRAIN, 8'h03);
		@(posedge i_clk);
		m_ext_en <= 1'b0;
		settle();
		chk(pm_pad.reduced & pm_pad.oe, 8'h0e);
		chk(pm_pad.oe, 8'h0e);
		chk(pm_pad.out & pm_pad.oe, 8'h04);
		chk(pm_pad.pull_en, 8'hf3);
		chk(pm_pad.pull_down & pm_pad.pull_en, 8'hf0);
		rchk(pmpi_pkg::IDX_M_PIN_INPUT, 8'h05);
		@(posedge i_clk);
		m_ext_en <= 1'b1;
	endtask

	// Direction 0x55 puts receive pins as outputs and transmit pins as inputs, so forcing shows.
	task automatic can_case(input logic [7:0] rt, input int rx, input logic txv);
		logic [7:0] rxm;
		logic [7:0] oe;
		rxm = (rx < 0) ? 8'h00 : 8'h01 << rx;
		oe = (8'h55 & ~rxm) | (rxm << 1);
		wreg(pmpi_pkg::IDX_MODULE_ROUTING, rt);
		settle();
		chk(pm_pad.oe, oe);
		chk(pm_pad.out & oe, txv ? rxm << 1 : 8'h00);
		chk(pm_pad.pull_en, ~oe & ~rxm);
		rchk(pmpi_pkg::IDX_M_DIRECTION, 8'h55);
	endtask

	task automatic t_can;
		wreg(pmpi_pkg::IDX_M_DATA, 8'h00);
		wreg(pmpi_pkg::IDX_M_DIRECTION, 8'h55);
		wreg(pmpi_pkg::IDX_M_PULL_POLARITY, 8'hff);
		wreg(pmpi_pkg::IDX_M_OPEN_DRAIN, 8'h00);
		mv = '0;
		mv.can_first_en = 1'b1;
		mv.can_first_tx = 1'b1;
		set_m();
		for (int c = 0; c < 4; c++) can_case(c[7:0], (c < 3) ? 2 * c : -1, 1'b1);
		mv = '0;
		mv.can_fifth_en = 1'b1;
		mv.can_fifth_tx = 1'b1;
		set_m();
		can_case(8'h00, -1, 1'b1);
		can_case(8'h04, 4, 1'b1);
		can_case(8'h08, 6, 1'b1);
		can_case(8'h0c, -1, 1'b1);
		mv.can_fifth_tx = 1'b0;
		mv.can_first_en = 1'b1;
		mv.can_first_tx = 1'b1;
		set_m();
		can_case(8'h06, 4, 1'b1);
		mv.can_second_en = 1'b1;
		mv.can_second_tx = 1'b1;
		mv.can_first_tx = 1'b0;
		set_m();
		can_case(8'h01, 2, 1'b1);
		mv = '0;
		mv.can_first_en = 1'b1;
		mv.can_first_tx = 1'b1;
		set_m();
		wreg(pmpi_pkg::IDX_M_OPEN_DRAIN, 8'hff);
		wreg(pmpi_pkg::IDX_MODULE_ROUTING, 8'h00);
		settle();
		chk(pm_pad.oe, 8'h54);
		wreg(pmpi_pkg::IDX_M_OPEN_DRAIN, 8'h00);
	endtask

	task automatic t_spi;
		mv = '0;
		mv.spi_first_en = 1'b1;
		mv.spi_first_sck = 1'b1;
		mv.spi_first_sck_oe = 1'b1;
		mv.spi_first_mosi_oe = 1'b1;
		set_m();
		wreg(pmpi_pkg::IDX_MODULE_ROUTING, 8'h10);
		settle();
		chk(pm_pad.oe, 8'h71);
		chk(pm_pad.out & pm_pad.oe, 8'h20);
		mv.spi_first_bidir = 1'b1;
		set_m();
		settle();
		chk(pm_pad.oe, 8'h75);
		wreg(pmpi_pkg::IDX_MODULE_ROUTING, 8'h00);
		settle();
		chk(pm_pad.oe, 8'h55);
		mv = '0;
		set_m();
	endtask

	task automatic t_p;
		pv = '0;
		pv.pwm_en = 8'h81;
		pv.pwm7_shutdown = 1'b1;
		pv.pwm_out = 8'h01;
		pv.spi_en = 8'h06;
		pv.spi_oe = 8'h02;
		pv.spi_out = 8'h02;
		@(posedge i_clk);
		pper <= pv;
		wreg(pmpi_pkg::IDX_P_DIRECTION, 8'hff);
		wreg(pmpi_pkg::IDX_P_PULL_ENABLE, 8'hff);
		wreg(pmpi_pkg::IDX_P_EDGE_POLARITY, 8'h80);
		settle();
		chk(pp_pad.oe, 8'h7b);
		chk(pp_pad.out & pp_pad.oe, 8'h03);
		chk(pp_pad.pull_en, 8'h84);
		chk(pp_pad.pull_down & pp_pad.pull_en, 8'h80);
		wreg(pmpi_pkg::IDX_MODULE_ROUTING, 8'h20);
		settle();
		chk(pp_pad.oe, 8'h7f);
		@(posedge i_clk);
		pper <= '0;
		wreg(pmpi_pkg::IDX_MODULE_ROUTING, 8'h00);
		wreg(pmpi_pkg::IDX_P_DIRECTION, 8'h00);
		wreg(pmpi_pkg::IDX_P_PULL_ENABLE, 8'h00);
	endtask

	task automatic t_flags;
		wreg(pmpi_pkg::IDX_P_EDGE_POLARITY, 8'h0f);
		settle();
		wreg(pmpi_pkg::IDX_P_IRQ_FLAGS, 8'hff);
		rchk(pmpi_pkg::IDX_P_IRQ_FLAGS, 8'h00);
		@(posedge i_clk);
		p_ext <= 8'hff;
		settle();
		chk(pp_sync, 8'hff);
		rchk(pmpi_pkg::IDX_P_IRQ_FLAGS, 8'h0f);
		chk({7'h00, irq}, 8'h00);
		@(posedge i_clk);
		p_ext <= 8'h00;
		settle();
		rchk(pmpi_pkg::IDX_P_IRQ_FLAGS, 8'hff);
		wreg(pmpi_pkg::IDX_P_IRQ_ENABLE, 8'h10);
		settle();
		chk({7'h00, irq}, 8'h01);
		wreg(pmpi_pkg::IDX_P_IRQ_FLAGS, 8'h10);
		rchk(pmpi_pkg::IDX_P_IRQ_FLAGS, 8'hef);
		settle();
		chk({7'h00, irq}, 8'h00);
		wreg(pmpi_pkg::IDX_P_IRQ_FLAGS, 8'h00);
		rchk(pmpi_pkg::IDX_P_IRQ_FLAGS, 8'hef);
		wreg(pmpi_pkg::IDX_P_IRQ_ENABLE, 8'hef);
		settle();
		chk({7'h00, irq}, 8'h01);
		// The pin moves three edges before the write is taken, so the edge meets the clear.
		@(posedge i_clk);
		p_ext <= 8'h08;
		@(posedge i_clk);
		wreg(pmpi_pkg::IDX_P_IRQ_FLAGS, 8'h09);
		rchk(pmpi_pkg::IDX_P_IRQ_FLAGS, 8'hee);
	endtask

	// ==========================================================
	// Verdict, main sequence and watchdog
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Every input gets a value at time zero before reset is released.
	initial begin
		i_sys_rst = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		be = 4'hf;
		addr = 6'h00;
		wdata = 32'h0000_0000;
		mper = '0;
		pper = '0;
		m_ext = 8'h00;
		p_ext = 8'h00;
		m_ext_en = 1'b1;
		p_ext_en = 1'b1;
		mismatches = 0;
		check_count = 0;
		repeat (3) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		t_reset();
		t_gpio();
		t_can();
		t_spi();
		t_p();
		t_flags();
		complete_run();
	end

	// The whole sequence needs well under two thousand cycles.
	initial begin
		repeat (5000) @(posedge i_clk);
		mismatches++;
		$display("unexpected at %0t: watchdog expired", $time);
		complete_run();
	end
endmodule
